/* File: src/ctc_device.sv */
// Summary of operation
// - Line length fields report eight words
// - Associativity fields report four way
// - Top bits zero, type code, separate caches
// - Data size 8KB, instruction size 16KB
// - Reserved and multiplier bits read zero
// - Read-only memory-fitted status word provided
// - Reset clears stored control bits except two strapped bits
// - Bit 13 strapped from high vector pin
// - Bit 7 strapped from big endian pin
// - Top control bits: write zero, read anything
// - Fixed ones and zeros in control word
// - Bit 15 selects legacy pc load behaviour
// - Bit 14 selects round robin replacement
// - Bits 12 and 2 enable caches
// - Bit 0 enables memory management
// - Bits 9, 8 drive protection logic
// - Bit 1 enables alignment checking
// - Software should read-modify-write the control word
// - Issuer zeroes selector and opcode for control
// - Opcode 1 description, opcode 2 memory status
`include "ctc_defines.svh"
module ctc_device #(
    parameter logic [31:0] TCM_STATUS = 32'h0000_0000
) (
    input wire logic pclk,
    input wire logic presetn,
    ctc_if.device bus,
    input wire logic high_vector_boot_pin,
    input wire logic big_endian_boot_pin,
    output logic mmu_enable,
    output logic align_check,
    output logic dcache_enable,
    output logic big_endian,
    output logic sys_protect,
    output logic rom_protect,
    output logic icache_enable,
    output logic high_vectors,
    output logic round_robin_select,
    output logic legacy_pc_load_flag
);
    // ****************************************************************
    // Constant words
    // ****************************************************************
    localparam logic [11:0] DSIZE = {`CTC_CT_RSV, `CTC_CT_DSIZE, `CTC_CT_ASSOC,
        `CTC_CT_MULT, `CTC_CT_LEN};
    localparam logic [11:0] ISIZE = {`CTC_CT_RSV, `CTC_CT_ISIZE, `CTC_CT_ASSOC,
        `CTC_CT_MULT, `CTC_CT_LEN};
    localparam logic [31:0] CTYPE_WORD = {`CTC_CT_TOP, `CTC_CT_CTYPE, `CTC_CT_SEP,
        DSIZE, ISIZE};
    localparam logic [31:0] CTRL_RW = `CTC_CTRL_RW;
    localparam logic [31:0] CTRL_ONES = `CTC_CTRL_ONES;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // A forced one that is also stored would look writable yet still read one after any write
    if ((CTRL_RW & CTRL_ONES) != 32'h0000_0000) begin : g_bad_masks
        $error("stored and forced control bits overlap");
    end
    // Strapped bits must be stored bits, or tracking would never hand over
    if (!CTRL_RW[`CTC_B_HIVEC] || !CTRL_RW[`CTC_B_BIGEND]) begin : g_bad_straps
        $error("strapped control bits are not stored");
    end
    // The top bits always read zero here, so none may be stored
    if (CTRL_RW[31:19] != 13'h0) begin : g_bad_top
        $error("reserved control bits are stored");
    end

    // ****************************************************************
    // Selector decoding
    // ****************************************************************
    // Shared by the write strobe and the read mux so both keep one map
    function automatic logic is_ctrl_sel(input logic [3:0] crn);
        return crn == `CTC_CRN_CTRL;
    endfunction : is_ctrl_sel

    function automatic logic is_c0_sel(input logic [3:0] crn);
        return crn == `CTC_CRN_ID;
    endfunction : is_c0_sel

    // ****************************************************************
    // Strap sampling
    // ****************************************************************
    localparam int NUM_STRAPS = 2;
    localparam int STRAP_HV = 0;
    localparam int STRAP_BE = 1;
    logic [NUM_STRAPS-1:0] strap_pin;
    logic [NUM_STRAPS-1:0] strap_lvl;
    logic strap_done_r;
    assign strap_pin[STRAP_HV] = high_vector_boot_pin;
    assign strap_pin[STRAP_BE] = big_endian_boot_pin;
    // Each strap is an asynchronous pin, so each gets its own sampler
    for (genvar g = 0; g < NUM_STRAPS; g++) begin : g_strap
        ctc_sync u_ctc_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(strap_pin[g]),
            .level(strap_lvl[g])
        );
    end

    // ****************************************************************
    // Control word
    // ****************************************************************
    logic [31:0] ctrl_r;
    logic take;
    logic wr_ctrl;
    assign take = bus.req && !bus.ack;
    assign wr_ctrl = take && bus.wr && is_ctrl_sel(bus.crn);
    // Strap tracking stops at the first control write, so software always wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_r <= 1'b0;
        end else if (wr_ctrl) begin
            strap_done_r <= 1'b1;
        end
    end
    // Straps settle through the sampler; a write before that wins over the strap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_ONES;
        end else if (wr_ctrl) begin
            // Only defined bits store; fixed and top bits hold their read value
            ctrl_r <= (bus.wdata & CTRL_RW) | CTRL_ONES;
        end else if (!strap_done_r) begin
            ctrl_r[`CTC_B_HIVEC] <= strap_lvl[STRAP_HV];
            ctrl_r[`CTC_B_BIGEND] <= strap_lvl[STRAP_BE];
        end
    end

    // ****************************************************************
    // Output flops
    // ****************************************************************
    localparam int NUM_OUTS = 10;
    logic [NUM_OUTS-1:0] out_q;
    // Position in the control word of each output, in port order
    function automatic int out_pos(input int idx);
        int pos;
        pos = `CTC_B_MMU;
        case (idx)
            1: pos = `CTC_B_ALIGN;
            2: pos = `CTC_B_DCACHE;
            3: pos = `CTC_B_BIGEND;
            4: pos = `CTC_B_SYSPROT;
            5: pos = `CTC_B_ROMPROT;
            6: pos = `CTC_B_ICACHE;
            7: pos = `CTC_B_HIVEC;
            8: pos = `CTC_B_RRSEL;
            9: pos = `CTC_B_LEGACY;
            default: pos = `CTC_B_MMU;
        endcase
        return pos;
    endfunction : out_pos
    // One flop per output; users see the control word one cycle late
    for (genvar g = 0; g < NUM_OUTS; g++) begin : g_out
        logic q_r;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                q_r <= 1'b0;
            end else begin
                q_r <= ctrl_r[out_pos(g)];
            end
        end
        assign out_q[g] = q_r;
    end
    assign mmu_enable = out_q[0];
    assign align_check = out_q[1];
    assign dcache_enable = out_q[2];
    assign big_endian = out_q[3];
    assign sys_protect = out_q[4];
    assign rom_protect = out_q[5];
    assign icache_enable = out_q[6];
    assign high_vectors = out_q[7];
    assign round_robin_select = out_q[8];
    assign legacy_pc_load_flag = out_q[9];

    // ****************************************************************
    // Read mux and acknowledge
    // ****************************************************************
    function automatic logic [31:0] rd_sel(input logic [3:0] crn, input logic [2:0] op2);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (is_ctrl_sel(crn)) begin
            v = ctrl_r;
        end else if (is_c0_sel(crn)) begin
            case (op2)
                `CTC_OP2_CTYPE: v = CTYPE_WORD;
                `CTC_OP2_TCM: v = TCM_STATUS;
                default: v = `CTC_ID_VALUE;
            endcase
        end
        return v;
    endfunction : rd_sel

    // Every request is answered one cycle later, read or write alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.ack <= 1'b0;
        end else begin
            bus.ack <= take;
        end
    end
    // Writes to c0 fall through here unused: no store, no side effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.rdata <= 32'h0000_0000;
        end else if (take && !bus.wr) begin
            bus.rdata <= rd_sel(bus.crn, bus.op2);
        end
    end
endmodule : ctc_device

/* File: inc/ctc_defines.svh */
`ifndef CTC_DEFINES_SVH
`define CTC_DEFINES_SVH

// ****************************************************************
// Transfer selector codes
// ****************************************************************
`define CTC_CRN_ID 4'h0
`define CTC_CRN_CTRL 4'h1
`define CTC_OP2_ID 3'h0
`define CTC_OP2_CTYPE 3'h1
`define CTC_OP2_TCM 3'h2

// ****************************************************************
// Cache description fields
// ****************************************************************
`define CTC_CT_TOP 3'h0
`define CTC_CT_CTYPE 4'hE
`define CTC_CT_SEP 1'h1
`define CTC_CT_RSV 2'h0
`define CTC_CT_DSIZE 4'h4
`define CTC_CT_ISIZE 4'h5
`define CTC_CT_ASSOC 3'h2
`define CTC_CT_MULT 1'h0
`define CTC_CT_LEN 2'h2

// ****************************************************************
// Control word bit positions
// ****************************************************************
`define CTC_B_MMU 0
`define CTC_B_ALIGN 1
`define CTC_B_DCACHE 2
`define CTC_B_BIGEND 7
`define CTC_B_SYSPROT 8
`define CTC_B_ROMPROT 9
`define CTC_B_ICACHE 12
`define CTC_B_HIVEC 13
`define CTC_B_RRSEL 14
`define CTC_B_LEGACY 15
`define CTC_CTRL_ONES 32'h0005_0078
`define CTC_CTRL_RW 32'h0000_F387
// Identity word: the value is arbitrary
`define CTC_ID_VALUE 32'h1234_5670

// ****************************************************************
// APB register offsets of the controller
// ****************************************************************
`define CTC_A_CMD 12'h000
`define CTC_A_WDATA 12'h004
`define CTC_A_RDATA 12'h008
`define CTC_A_STATUS 12'h00C
`define CTC_CMD_GO 8
`define CTC_CMD_WR 9

`endif

/* File: inc/ctc_pkg.sv */
package ctc_pkg;
    typedef enum logic [1:0] {
        CTC_IDLE = 2'b00,
        CTC_REQ = 2'b01,
        CTC_WAIT = 2'b10
    } ctc_state_type;
endpackage : ctc_pkg

/* File: inc/ctc_if.sv */
interface ctc_if;
    logic req;
    logic wr;
    logic [3:0] crn;
    logic [3:0] secondary_reg_selector;
    logic [2:0] op2;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    modport device (input req, wr, crn, secondary_reg_selector, op2, wdata,
                    output ack, rdata);
    modport core (output req, wr, crn, secondary_reg_selector, op2, wdata,
                  input ack, rdata);
endinterface : ctc_if

/* File: src/ctc_sync.sv */
module ctc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    // ****************************************************************
    // Three stage pin sampler
    // ****************************************************************
    logic s1_r, s2_r, s3_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // A change counts only once two settled stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= 1'b0;
        end else if (s2_r == s3_r) begin
            level <= s3_r;
        end
    end
endmodule : ctc_sync

/* File: src/ctc_core.sv */
`include "ctc_defines.svh"
module ctc_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ctc_if.core bus
);
    // ****************************************************************
    // Software registers
    // ****************************************************************
    logic [31:0] wdata_r, rdata_r;
    logic [9:0] cmd_r;
    logic busy_r, done_r;
    ctc_pkg::ctc_state_type state_r;
    logic go;
    logic acc;
    assign acc = psel && penable;
    assign go = acc && pwrite && paddr == `CTC_A_CMD && pwdata[`CTC_CMD_GO] && !busy_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_r <= 32'h0000_0000;
            cmd_r <= 10'h000;
        end else if (acc && pwrite && !busy_r) begin
            if (paddr == `CTC_A_WDATA) wdata_r <= pwdata;
            if (paddr == `CTC_A_CMD) cmd_r <= pwdata[9:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `CTC_A_CMD: prdata <= {22'h000000, cmd_r};
                    `CTC_A_WDATA: prdata <= wdata_r;
                    `CTC_A_RDATA: prdata <= rdata_r;
                    `CTC_A_STATUS: prdata <= {30'h00000000, done_r, busy_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    // Selector field is always issued as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ctc_pkg::CTC_IDLE;
            bus.req <= 1'b0;
            bus.wr <= 1'b0;
            bus.crn <= 4'h0;
            bus.secondary_reg_selector <= 4'h0;
            bus.op2 <= 3'h0;
            bus.wdata <= 32'h0000_0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                ctc_pkg::CTC_IDLE: begin
                    if (go) begin
                        bus.req <= 1'b1;
                        bus.wr <= pwdata[`CTC_CMD_WR];
                        bus.crn <= pwdata[3:0];
                        bus.secondary_reg_selector <= 4'h0;
                        // Control word transfers force opcode zero
                        bus.op2 <= (pwdata[3:0] == `CTC_CRN_CTRL) ? 3'h0 : pwdata[6:4];
                        bus.wdata <= wdata_r;
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        state_r <= ctc_pkg::CTC_WAIT;
                    end
                end
                ctc_pkg::CTC_WAIT: begin
                    if (bus.ack) begin
                        bus.req <= 1'b0;
                        rdata_r <= bus.rdata;
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= ctc_pkg::CTC_IDLE;
                    end
                end
                default: state_r <= ctc_pkg::CTC_IDLE;
            endcase
        end
    end
endmodule : ctc_core

/* File: sim/ctc_link_asserts.sv */
// ************************************************
// Link protocol and register content checks
// ************************************************
module ctc_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [3:0] crn,
    input wire logic [3:0] secondary_reg_selector,
    input wire logic [2:0] op2,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ack_next_cycle: assert property (req && !ack |=> ack)
        else $error("answer not one cycle after request");
    chk_ack_single: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("answer without request");
    chk_req_drop: assert property (ack |=> !req)
        else $error("request kept after answer");
    chk_req_hold: assert property (req && !ack |=> $stable(wr) && $stable(crn)
        && $stable(op2) && $stable(wdata)) else $error("request changed while pending");
    chk_ctrl_selects: assert property (
        req && crn == 4'h1 |-> op2 == 3'h0 && secondary_reg_selector == 4'h0)
        else $error("control transfer with nonzero selectors");
    chk_cache_word: assert property (
        ack && !wr && crn == 4'h0 && op2 == 3'h1 |-> rdata == 32'h1D11_2152)
        else $error("cache description word wrong");
    chk_mem_status: assert property (
        ack && !wr && crn == 4'h0 && op2 == 3'h2 |-> rdata == 32'h0)
        else $error("memory status word wrong");
    chk_ctrl_fixed: assert property (
        ack && !wr && crn == 4'h1 |-> (rdata & 32'h0007_0C78) == 32'h0005_0078)
        else $error("fixed control bits wrong");
endmodule : ctc_link_asserts

/* File: sim/tb.sv */
`include "ctc_defines.svh"
// ************************************************
// Bench top
// ************************************************
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hv_pin, be_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] o;
    int err_total, comparisons;
    ctc_if lnk();
    ctc_core u_ctc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(lnk));
    ctc_device u_ctc_device (.pclk(pclk), .presetn(presetn), .bus(lnk),
        .high_vector_boot_pin(hv_pin), .big_endian_boot_pin(be_pin), .mmu_enable(o[0]),
        .align_check(o[1]), .dcache_enable(o[2]), .big_endian(o[3]), .sys_protect(o[4]),
        .rom_protect(o[5]), .icache_enable(o[6]), .high_vectors(o[7]),
        .round_robin_select(o[8]), .legacy_pc_load_flag(o[9]));
    ctc_link_asserts u_chk (.pclk(pclk), .presetn(presetn), .req(lnk.req), .wr(lnk.wr),
        .crn(lnk.crn), .secondary_reg_selector(lnk.secondary_reg_selector), .op2(lnk.op2),
        .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Waits are bounded so a dead slave ends the run instead of hanging it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        r = prdata;
        check("pslverr", {31'h0, pslverr}, 32'h0);
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin
            err_total++;
            final_report();
        end
    endtask : apb
    task link(input logic [3:0] cn, input logic [2:0] o2, input logic w,
              input logic [31:0] d, output logic [31:0] r);
        logic [31:0] s;
        apb(1'h1, `CTC_A_WDATA, d, s);
        apb(1'h1, `CTC_A_CMD, {22'h0, w, 1'h1, 1'h0, o2, cn}, s);
        for (int i = 0; i < 20; i++) begin
            apb(1'h0, `CTC_A_STATUS, 32'h0, s);
            if (s[1:0] === 2'h2) break;
        end
        if (s[1:0] !== 2'h2) begin
            err_total++;
            final_report();
        end
        apb(1'h0, `CTC_A_RDATA, 32'h0, r);
    endtask : link
    task outs(input logic [31:0] e);
        check("outputs", {22'h0, o}, {22'h0, e[15:12], e[9:7], e[2:0]});
    endtask : outs
    task rst(input logic hv, input logic be);
        presetn <= 1'h0; hv_pin <= hv; be_pin <= be;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (8) @(posedge pclk);
    endtask : rst
    task t_reset;
        logic [31:0] e;
        for (int i = 0; i < 2; i++) begin
            rst(i == 0, i == 1);
            e = 32'h0005_0078 | ((i == 0) ? 32'h0000_2000 : 32'h0000_0080);
            link(4'h1, 3'h0, 1'h0, 32'h0, rd);
            check("ctrl reset", rd & 32'h0007_FFFF, e);
            outs(e);
        end
        $display("test reset done");
    endtask : t_reset
    task t_ctype;
        link(4'h0, 3'h1, 1'h0, 32'h0, rd);
        check("cache word", rd, 32'h1D11_2152);
        link(4'h0, 3'h1, 1'h1, 32'hFFFF_FFFF, rd);
        link(4'h0, 3'h1, 1'h0, 32'h0, rd);
        check("cache word kept", rd, 32'h1D11_2152);
        link(4'h0, 3'h2, 1'h0, 32'h0, rd);
        check("mem status", rd, 32'h0);
        link(4'h0, 3'h2, 1'h1, 32'hFFFF_FFFF, rd);
        link(4'h0, 3'h2, 1'h0, 32'h0, rd);
        check("mem status kept", rd, 32'h0);
        link(4'h0, 3'h5, 1'h0, 32'h0, rd);
        check("id word", rd, `CTC_ID_VALUE);
        link(4'h2, 3'h0, 1'h0, 32'h0, rd);
        check("unmapped crn", rd, 32'h0);
        $display("test description done");
    endtask : t_ctype
    task t_ctrl;
        logic [31:0] v[2];
        v = '{32'h0005_F3FF, 32'h0005_0078};
        for (int i = 0; i < 2; i++) begin
            link(4'h1, 3'h3, 1'h1, v[i], rd);
            link(4'h1, 3'h0, 1'h0, 32'h0, rd);
            check("ctrl", rd & 32'h0007_FFFF, v[i]);
            outs(v[i]);
        end
        $display("test control done");
    endtask : t_ctrl
    task t_rmw;
        link(4'h1, 3'h0, 1'h0, 32'h0, rd);
        link(4'h1, 3'h0, 1'h1, rd | 32'h0000_4001, rd);
        apb(1'h0, `CTC_A_WDATA, 32'h0, rd);
        check("wdata readback", rd, 32'h0005_4079);
        apb(1'h0, `CTC_A_CMD, 32'h0, rd);
        check("cmd readback", rd, 32'h0000_0301);
        link(4'h1, 3'h0, 1'h0, 32'h0, rd);
        check("ctrl rmw", rd & 32'h0007_FFFF, 32'h0005_4079);
        outs(32'h0005_4079);
        apb(1'h0, 12'h010, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("test modify done");
    endtask : t_rmw
    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 12'h0; pwdata = 32'h0; hv_pin = 1'h0; be_pin = 1'h0;
        err_total = 0;
        comparisons = 0;
        t_reset;
        t_ctype;
        t_ctrl;
        t_rmw;
        final_report;
    end
endmodule : tb
